/* File: core/tick_timer_pkg.sv */
package tick_timer_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_CTRL = 10'h036;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h037;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h038;
    localparam logic [9:0] IDX_TICK_COUNT = 10'h039;
    localparam logic [9:0] IDX_LIVE = 10'h03a;

    localparam logic [11:0] ADDR_CTRL = {IDX_CTRL, 2'h0};
    localparam logic [11:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'h0};
    localparam logic [11:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'h0};
    localparam logic [11:0] ADDR_TICK_COUNT = {IDX_TICK_COUNT, 2'h0};
    localparam logic [11:0] ADDR_LIVE = {IDX_LIVE, 2'h0};

    // control register field positions
    localparam int CTRL_TAP_LSB = 0;
    localparam int CTRL_TAP_MSB = 2;
    localparam int CTRL_ENABLE_BIT = 3;
    localparam int CTRL_SOURCE_BIT = 4;
    localparam int CTRL_BUZZ_RATE_LSB = 5;
    localparam int CTRL_BUZZ_RATE_MSB = 6;
    localparam int CTRL_BUZZ_EN_BIT = 7;

    // interrupt status / mask bit positions
    localparam int IRQ_TICK_BIT = 0;
    localparam int IRQ_BAD_SEL_BIT = 1;
    localparam int IRQ_WIDTH = 2;

    // live register field positions
    localparam int LIVE_TAP_BIT = 0;
    localparam int LIVE_SRC_BIT = 1;
    localparam int LIVE_VALID_BIT = 2;
    localparam int LIVE_LOW_SPEED_BIT = 3;

    // reset values and tick count step
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] IRQ_STATUS_RESET = 2'h0;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
    localparam logic [15:0] TICK_COUNT_RESET = 16'h0000;
    localparam logic [15:0] TICK_COUNT_STEP = 16'h0001;

    // divider widths: bit k of a divider vector is clock / 2^(k+1)
    localparam int HF_DIV_WIDTH = 23;
    localparam int LF_DIV_WIDTH = 15;

    // tap bit index per select code, element [code]
    localparam logic [7:0][4:0] HF_TAP_IDX = {
        5'h08, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0f, 5'h14, 5'h16
    };
    localparam logic [7:0][4:0] LF_TAP_IDX = {
        5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h0c, 5'h0e
    };
    // highest select code usable on the sub clock in low-speed modes
    localparam logic [2:0] LOW_SPEED_MAX_TAP = 3'h1;

    typedef enum logic [1:0] {
        MODE_FULL_RUN = 2'h0,
        MODE_CORE_HALTED = 2'h1,
        MODE_LOW_SPEED = 2'h2,
        MODE_LOW_SPEED_HALTED = 2'h3
    } op_mode_t;

    typedef struct packed {
        logic buzzer_output_enable;
        logic [1:0] buzzer_rate_select;
        logic divider_source_select;
        logic tick_enable;
        logic [2:0] tick_tap_select;
    } time_base_control_t;

    typedef struct packed {
        logic source_low;
        logic [2:0] tap;
    } tap_key_t;

endpackage

/* File: core/tap_edge_detect.sv */
`timescale 1ns/1ps
`default_nettype none
module tap_edge_detect (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic tap_i,
    input wire logic restart_i,
    input wire logic arm_i,
    output logic fall_o
);
    logic prev_r;
    logic prev_nxt;
    logic fall_r;
    logic fall_nxt;

    always_comb begin
        prev_nxt = tap_i;
        // a new tap compares against itself, never against the old one
        fall_nxt = arm_i & ~restart_i & prev_r & ~tap_i; // RULE_07
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prev_r <= 1'b0;
            fall_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            fall_r <= fall_nxt;
        end
    end

    assign fall_o = fall_r;
endmodule
`default_nettype wire

/* File: core/periodic_tick_interrupt_timer.sv */
// How it works
// RULE_01 - reset clears the whole control register: timer off, slowest tap.
// RULE_02 - fast source: codes pick fast clock over 2^23,21,16,14,13,12,11,9.
// RULE_03 - sub source: 2^15,13,8,6,5,4,3,1; low-speed modes allow codes 0,1 only.
// RULE_04 - software changes the tap select only while the timer is off.
// RULE_05 - the write that disables the timer keeps the tap select unchanged.
// RULE_06 - one write may load a new tap and enable; new rate applies.
// RULE_07 - each falling edge of the chosen tap while enabled raises a tick.
// RULE_08 - the shared divider is never reset, so the first tick may come early.
// RULE_09 - no ticks while disabled; each edge gives exactly one one-cycle pulse.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module periodic_tick_interrupt_timer (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [1:0] mode_i,
    input wire logic [22:0] high_freq_div_i,
    input wire logic [14:0] low_freq_div_i,
    output logic tick_interrupt_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    logic setup_phase;
    logic access_phase;
    logic wr_access;
    logic lane0_wr;
    logic ctrl_wr;
    logic status_wr;
    logic mask_wr;
    logic hit_ctrl;
    logic hit_status;
    logic hit_mask;
    logic hit_count;
    logic hit_live;
    logic hit_any;

    always_comb begin
        setup_phase = psel_i & ~penable_i;
        access_phase = psel_i & penable_i;
        hit_ctrl = (paddr_i == tick_timer_pkg::ADDR_CTRL);
        hit_status = (paddr_i == tick_timer_pkg::ADDR_IRQ_STATUS);
        hit_mask = (paddr_i == tick_timer_pkg::ADDR_IRQ_MASK);
        hit_count = (paddr_i == tick_timer_pkg::ADDR_TICK_COUNT);
        hit_live = (paddr_i == tick_timer_pkg::ADDR_LIVE);
        hit_any = hit_ctrl | hit_status | hit_mask | hit_count | hit_live;
        wr_access = access_phase & pwrite_i;
        // control, status and mask fields sit in the low byte, so only lane 0 matters for their writes
        lane0_wr = wr_access & pstrb_i[0];
        ctrl_wr = lane0_wr & hit_ctrl;
        status_wr = lane0_wr & hit_status;
        mask_wr = lane0_wr & hit_mask;
    end

    // zero wait states; an unmapped address answers with an error
    assign pready_o = 1'b1;
    assign pslverr_o = access_phase & ~hit_any;

    ////////////////////////////////////////////////////////////////////////
    // control register

    tick_timer_pkg::time_base_control_t ctrl_r;
    tick_timer_pkg::time_base_control_t ctrl_nxt;

    always_comb begin
        ctrl_nxt = ctrl_r;
        // tap and enable land together, edge history restarts below
        if (ctrl_wr) begin
            ctrl_nxt = tick_timer_pkg::time_base_control_t'(pwdata_i[7:0]); // RULE_06
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_r <= tick_timer_pkg::time_base_control_t'(tick_timer_pkg::CTRL_RESET); // RULE_01
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // tap selection

    tick_timer_pkg::op_mode_t mode;
    logic low_speed;
    logic source_low;
    logic sel_valid;
    logic [4:0] hf_idx;
    logic [4:0] lf_idx;
    logic tap_level;
    tick_timer_pkg::tap_key_t key;

    always_comb begin
        mode = tick_timer_pkg::op_mode_t'(mode_i);
        case (mode)
            tick_timer_pkg::MODE_LOW_SPEED: low_speed = 1'b1;
            tick_timer_pkg::MODE_LOW_SPEED_HALTED: low_speed = 1'b1;
            default: low_speed = 1'b0;
        endcase
        // low-speed modes only have the sub clock to run on
        source_low = ctrl_r.divider_source_select | low_speed;
        hf_idx = tick_timer_pkg::HF_TAP_IDX[ctrl_r.tick_tap_select]; // RULE_02
        lf_idx = tick_timer_pkg::LF_TAP_IDX[ctrl_r.tick_tap_select]; // RULE_03
        // invalid low-speed codes give no ticks rather than a wrong rate
        sel_valid = ~low_speed |
            (ctrl_r.tick_tap_select <= tick_timer_pkg::LOW_SPEED_MAX_TAP); // RULE_03
        if (source_low) begin
            tap_level = low_freq_div_i[lf_idx[3:0]] & sel_valid;
        end else begin
            tap_level = high_freq_div_i[hf_idx];
        end
        key.source_low = source_low;
        key.tap = ctrl_r.tick_tap_select;
    end

    ////////////////////////////////////////////////////////////////////////
    // edge history restart on any change of the tap in use

    tick_timer_pkg::tap_key_t key_r;
    tick_timer_pkg::tap_key_t key_nxt;
    logic restart;
    logic tick_arm;

    always_comb begin
        key_nxt = key;
        tick_arm = ctrl_r.tick_enable & sel_valid; // RULE_09
        // a switch must not look like a falling edge of the new tap
        restart = (key != key_r); // RULE_04
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            key_r <= tick_timer_pkg::tap_key_t'(4'h0);
        end else begin
            key_r <= key_nxt;
        end
    end

    // the divider taps come in running; nothing here ever clears them
    logic tick_pulse;

    tap_edge_detect u_edge (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .tap_i(tap_level), // RULE_08
        .restart_i(restart),
        .arm_i(tick_arm), // RULE_09
        .fall_o(tick_pulse) // RULE_07
    );

    assign tick_interrupt_o = tick_pulse; // RULE_09

    ////////////////////////////////////////////////////////////////////////
    // bad selection event

    logic bad_sel;
    logic bad_sel_r;
    logic bad_sel_nxt;
    logic bad_sel_rise;

    always_comb begin
        bad_sel = ctrl_r.tick_enable & ~sel_valid;
        bad_sel_nxt = bad_sel;
        bad_sel_rise = bad_sel & ~bad_sel_r;
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bad_sel_r <= 1'b0;
        end else begin
            bad_sel_r <= bad_sel_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status and mask

    logic [1:0] irq_status_r;
    logic [1:0] irq_status_nxt;
    logic [1:0] irq_mask_r;
    logic [1:0] irq_mask_nxt;
    logic [1:0] irq_events;
    logic [1:0] irq_clear;
    logic irq_r;
    logic irq_nxt;

    always_comb begin
        irq_events = '0;
        irq_events[tick_timer_pkg::IRQ_TICK_BIT] = tick_pulse;
        irq_events[tick_timer_pkg::IRQ_BAD_SEL_BIT] = bad_sel_rise;
        irq_clear = '0;
        if (status_wr) begin
            irq_clear = pwdata_i[1:0];
        end
        // an event in the clearing cycle survives the clear
        irq_status_nxt = (irq_status_r & ~irq_clear) | irq_events;
        irq_mask_nxt = irq_mask_r;
        if (mask_wr) begin
            irq_mask_nxt = pwdata_i[1:0];
        end
        // built from next values, so the flop adds no cycle of delay
        irq_nxt = |(irq_status_nxt & irq_mask_nxt);
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_status_r <= tick_timer_pkg::IRQ_STATUS_RESET;
            irq_mask_r <= tick_timer_pkg::IRQ_MASK_RESET;
            irq_r <= |(tick_timer_pkg::IRQ_STATUS_RESET & tick_timer_pkg::IRQ_MASK_RESET);
        end else begin
            irq_status_r <= irq_status_nxt;
            irq_mask_r <= irq_mask_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign irq_o = irq_r;

    ////////////////////////////////////////////////////////////////////////
    // tick counter

    logic [15:0] tick_count_r;
    logic [15:0] tick_count_nxt;
    logic count_clear;

    always_comb begin
        count_clear = wr_access & hit_count & (pstrb_i[1:0] != 2'h0);
        tick_count_nxt = tick_count_r;
        if (count_clear) begin
            tick_count_nxt = tick_timer_pkg::TICK_COUNT_RESET;
        end
        // wraps silently; software reads the difference
        if (tick_pulse) begin
            tick_count_nxt = tick_count_nxt + tick_timer_pkg::TICK_COUNT_STEP;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tick_count_r <= tick_timer_pkg::TICK_COUNT_RESET;
        end else begin
            tick_count_r <= tick_count_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, captured in the setup cycle

    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [31:0] live_word;

    always_comb begin
        live_word = '0;
        live_word[tick_timer_pkg::LIVE_TAP_BIT] = tap_level;
        live_word[tick_timer_pkg::LIVE_SRC_BIT] = source_low;
        live_word[tick_timer_pkg::LIVE_VALID_BIT] = sel_valid;
        live_word[tick_timer_pkg::LIVE_LOW_SPEED_BIT] = low_speed;
        rdata_nxt = rdata_r;
        if (setup_phase && !pwrite_i) begin
            rdata_nxt = '0;
            if (hit_ctrl) begin
                rdata_nxt[7:0] = ctrl_r;
            end
            if (hit_status) begin
                rdata_nxt[1:0] = irq_status_r;
            end
            if (hit_mask) begin
                rdata_nxt[1:0] = irq_mask_r;
            end
            if (hit_count) begin
                rdata_nxt[15:0] = tick_count_r;
            end
            if (hit_live) begin
                rdata_nxt = live_word;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign prdata_o = rdata_r;

endmodule
`default_nettype wire

/* File: tb/tick_timer_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module tick_timer_checker (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [1:0] mode_i,
    input wire logic [22:0] high_freq_div_i,
    input wire logic [14:0] low_freq_div_i,
    input wire logic tick_interrupt_o,
    input wire logic irq_o
);
    localparam int HF_EXP [8] = '{23, 21, 16, 14, 13, 12, 11, 9};
    localparam int LF_EXP [8] = '{15, 13, 8, 6, 5, 4, 3, 1};
    logic [4:0] ctrl_r, ctrl_nxt;
    logic [1:0] mask_r, mask_nxt, mode_r;
    logic [2:0] quiet_r, quiet_nxt;
    logic wr_c, tap_c, ok_c, bad_c;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    ////////////////////////////////////////
    // shadow of control and mask; quiet_r counts cycles with no config change
    always_comb begin
        wr_c = psel_i && penable_i && pwrite_i && pstrb_i[0];
        ctrl_nxt = (wr_c && paddr_i == tick_timer_pkg::ADDR_CTRL) ? pwdata_i[4:0] : ctrl_r;
        mask_nxt = (wr_c && paddr_i == tick_timer_pkg::ADDR_IRQ_MASK) ? pwdata_i[1:0] : mask_r;
        quiet_nxt = (ctrl_nxt != ctrl_r || mode_i != mode_r) ? 3'h0 :
            quiet_r + {2'h0, quiet_r != 3'h7};
        tap_c = (ctrl_r[4] || mode_i[1]) ? low_freq_div_i[LF_EXP[ctrl_r[2:0]] - 1] :
            high_freq_div_i[HF_EXP[ctrl_r[2:0]] - 1];
        ok_c = !(mode_i[1] && ctrl_r[2:0] > 3'h1);
        bad_c = !(paddr_i inside {tick_timer_pkg::ADDR_CTRL, tick_timer_pkg::ADDR_IRQ_STATUS,
            tick_timer_pkg::ADDR_IRQ_MASK, tick_timer_pkg::ADDR_TICK_COUNT,
            tick_timer_pkg::ADDR_LIVE});
    end
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_r <= 5'h00;
            mask_r <= 2'h0;
            mode_r <= 2'h0;
            quiet_r <= 3'h0;
        end else begin
            ctrl_r <= ctrl_nxt;
            mask_r <= mask_nxt;
            mode_r <= mode_i;
            quiet_r <= quiet_nxt;
        end
    end
    ////////////////////////////////////////
    property p_pulse; tick_interrupt_o |=> !tick_interrupt_o; endproperty
    a_pulse: assert property (p_pulse) else $error("tick pulse too long");
    property p_idle; !ctrl_r[3] && !$past(ctrl_r[3]) |-> !tick_interrupt_o; endproperty
    a_idle: assert property (p_idle) else $error("tick while disabled");
    property p_cause; tick_interrupt_o |-> $past(tap_c, 2) && !$past(tap_c); endproperty
    a_cause: assert property (p_cause) else $error("tick without tap fall");
    property p_fall;
        quiet_r > 3'h2 && ctrl_r[3] && ok_c && $past(tap_c) && !tap_c |=> tick_interrupt_o;
    endproperty
    a_fall: assert property (p_fall) else $error("tap fall gave no tick");
    property p_low;
        !ok_c && $past(mode_i[1]) && $past(ctrl_r[2:0]) > 3'h1 |-> !tick_interrupt_o;
    endproperty
    a_low: assert property (p_low) else $error("tick on invalid low-speed tap");
    property p_irq_set; tick_interrupt_o && mask_r[0] |-> ##[1:2] irq_o; endproperty
    a_irq_set: assert property (p_irq_set) else $error("masked-in tick gave no irq");
    property p_irq_off; mask_r == 2'h0 && $past(mask_r) == 2'h0 |-> !irq_o; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq with all sources masked");
    property p_slverr; psel_i && penable_i && bad_c |-> pslverr_o && pready_o; endproperty
    a_slverr: assert property (p_slverr) else $error("unmapped access not flagged");
    c_tick: cover property (tick_interrupt_o);
    c_irq: cover property (irq_o);
    c_err: cover property (pslverr_o);
endmodule
`default_nettype wire

/* File: tb/tb_periodic_tick_interrupt_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_periodic_tick_interrupt_timer;
    localparam int HF_EXP [8] = '{23, 21, 16, 14, 13, 12, 11, 9};
    localparam int LF_EXP [8] = '{15, 13, 8, 6, 5, 4, 3, 1};
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, tick, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    logic [1:0] mode;
    logic [22:0] hf;
    logic [14:0] lf;
    int n_errors, checks_done, ticks, exp_cnt;
    periodic_tick_interrupt_timer dut_u (
        .sys_clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .mode_i(mode),
        .high_freq_div_i(hf), .low_freq_div_i(lf), .tick_interrupt_o(tick), .irq_o(irq)
    );
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (tick === 1'b1) ticks++;
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // trailing idle edge keeps back-to-back calls from driving psel twice in one step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // no limit here: a stuck slave is ended by the watchdog
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic end_sim();
        $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one-hot fall on the chosen tap only; noise on the unused divider must not tick
    task automatic run_tap(input logic [1:0] md, input logic src, input logic [2:0] c);
        int t0, e, k;
        logic [7:0] w;
        w = {3'($urandom), src, 1'b1, c};
        e = (md[1] && c > 3'h1) ? 0 : 2;
        k = (src || md[1]) ? LF_EXP[c] - 1 : HF_EXP[c] - 1;
        mode <= md;
        hf <= '1;
        lf <= '1;
        @(posedge clk);
        apb(1'b1, tick_timer_pkg::ADDR_CTRL, {24'h0, w});
        apb(1'b0, tick_timer_pkg::ADDR_CTRL, 32'h0);
        chk(q, {24'h0, w});
        t0 = ticks;
        repeat (2) begin
            hf <= (src || md[1]) ? 23'($urandom) : ~(23'h1 << k);
            lf <= (src || md[1]) ? ~(15'h1 << k) : 15'($urandom);
            repeat (3) @(posedge clk);
            hf <= '1;
            lf <= '1;
            repeat (3) @(posedge clk);
        end
        chk(32'(ticks - t0), 32'(e));
        exp_cnt += e;
        apb(1'b1, tick_timer_pkg::ADDR_CTRL, {24'h0, w & 8'hf7});
    endtask
    ////////////////////////////////////////
    initial begin
        int t0;
        {rstn, psel, penable, pwrite, paddr, pwdata, mode} = '0;
        pstrb = 4'hf;
        hf = '1;
        lf = '1;
        {n_errors, checks_done, ticks, exp_cnt} = '0;
        void'($urandom(32'h73bd6ecb));
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        apb(1'b0, tick_timer_pkg::ADDR_CTRL, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 12'hffc, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset_and_decode done");
        for (int s = 0; s < 2; s++) begin
            for (int c = 0; c < 8; c++) run_tap({1'b0, 1'($urandom)}, s[0], c[2:0]);
        end
        $display("test tap_map done");
        for (int c = 0; c < 8; c++) run_tap({1'b1, 1'($urandom)}, 1'($urandom), c[2:0]);
        $display("test low_speed done");
        hf <= '0;
        lf <= '0;
        t0 = ticks;
        repeat (5) @(posedge clk);
        chk(32'(ticks - t0), 32'h0);
        apb(1'b0, tick_timer_pkg::ADDR_TICK_COUNT, 32'h0);
        chk(q, 32'(exp_cnt));
        apb(1'b0, tick_timer_pkg::ADDR_IRQ_STATUS, 32'h0);
        chk(q, 32'h3);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, tick_timer_pkg::ADDR_IRQ_MASK, 32'h1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, tick_timer_pkg::ADDR_IRQ_STATUS, 32'h3);
        apb(1'b0, tick_timer_pkg::ADDR_IRQ_STATUS, 32'h0);
        chk(q, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test irq done");
        apb(1'b1, tick_timer_pkg::ADDR_CTRL, 32'h07);
        // lane 0 off: control write dropped, count clear still taken on lane 1
        pstrb <= 4'he;
        apb(1'b1, tick_timer_pkg::ADDR_CTRL, 32'hff);
        apb(1'b1, tick_timer_pkg::ADDR_TICK_COUNT, 32'h0);
        pstrb <= 4'hf;
        exp_cnt = 0;
        apb(1'b0, tick_timer_pkg::ADDR_CTRL, 32'h0);
        chk(q, 32'h07);
        apb(1'b0, tick_timer_pkg::ADDR_TICK_COUNT, 32'h0);
        chk(q, 32'(exp_cnt));
        // low-speed mode forces the sub clock and makes code 7 invalid
        apb(1'b0, tick_timer_pkg::ADDR_LIVE, 32'h0);
        chk(q, 32'ha);
        mode <= 2'h0;
        hf <= '1;
        apb(1'b0, tick_timer_pkg::ADDR_LIVE, 32'h0);
        chk(q, 32'h5);
        run_tap(2'h0, 1'b0, 3'h7);
        apb(1'b0, tick_timer_pkg::ADDR_IRQ_STATUS, 32'h0);
        chk(q, 32'h1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, tick_timer_pkg::ADDR_TICK_COUNT, 32'h0);
        chk(q, 32'(exp_cnt));
        $display("test strobe_live_irq done");
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_sim();
    end
endmodule
bind periodic_tick_interrupt_timer tick_timer_checker chk_u (
    .sys_clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
    .prdata_o, .pready_o, .pslverr_o, .mode_i, .high_freq_div_i, .low_freq_div_i,
    .tick_interrupt_o, .irq_o
);
`default_nettype wire
